// ---- design/shs_homing_sequencer.sv ----
// Homing sequencer: method state machine, register port and status outputs
`timescale 1ns/10ps
module shs_homing_sequencer #(
  parameter int STOP_CYCLES = shs_pkg::STOP_CYCLES
) (
  input  wire logic          clock_in,
  input  wire logic          reset_in,
  input  wire logic [7:0]    addr_in,
  input  wire logic [31:0]   wdata_in,
  input  wire logic          wr_in,
  input  wire logic          rd_in,
  output logic [31:0]        rdata_out,
  input  wire logic [31:0]   position_in,
  input  wire logic          limit_neg_in,
  input  wire logic          limit_pos_in,
  input  wire logic          index_in,
  input  wire logic          blocked_in,
  input  wire logic          enable_in,
  input  wire logic          multiturn_in,
  input  wire logic          pos_mode_in,
  input  wire logic          target_reached_in,
  input  wire logic          remaining_in,
  output shs_pkg::shs_motion_t motion_out,
  output logic               home_done_out,
  output logic               error_out,
  output logic               target_out,
  output logic               remain_out,
  output logic [31:0]        zero_pos_out
);

  localparam logic [27:0] STOP_LAST = 28'(STOP_CYCLES - 1);

  shs_pkg::shs_regs_t s;
  shs_pkg::shs_regs_t next_s;

  logic        start_req;
  logic        fin;
  logic [31:0] home_val;
  logic        lim_hit;
  logic        lim_rise;
  logic        lim_fall;
  logic        idx_rise;
  logic [31:0] trav;
  logic [31:0] trav_abs;
  logic        kind_lim;
  logic        kind_lim_idx;
  logic        kind_idx;
  logic        kind_stop;
  logic        kind_stop_idx;
  logic        beyond;
  logic        zero_reached;

  ////////////////////////////////////////////////////////////////////////////////

  // Method classification always follows the stored method
  always_comb begin
    kind_lim_idx  = (s.method == shs_pkg::M_LIM_NEG_IDX) || (s.method == shs_pkg::M_LIM_POS_IDX);
    kind_lim      = (s.method == shs_pkg::M_LIM_NEG) || (s.method == shs_pkg::M_LIM_POS);
    kind_idx      = (s.method == shs_pkg::M_IDX_NEG) || (s.method == shs_pkg::M_IDX_POS);
    kind_stop_idx = (s.method == shs_pkg::M_STOP_NEG_IDX) ||
                    (s.method == shs_pkg::M_STOP_POS_IDX);
    kind_stop     = (s.method == shs_pkg::M_STOP_NEG) || (s.method == shs_pkg::M_STOP_POS);
    lim_hit       = s.dir ? limit_pos_in : limit_neg_in;
    lim_rise      = lim_hit && !(s.dir ? s.prev_lim_p : s.prev_lim_n);
    lim_fall      = !lim_hit && (s.dir ? s.prev_lim_p : s.prev_lim_n);
    idx_rise      = index_in && !s.prev_idx;
    trav          = position_in - s.start_pos;
    trav_abs      = trav[31] ? (32'h0 - trav) : trav;
    beyond        = (s.method != shs_pkg::M_NONE) &&
                    (s.dir ? ($signed(s.offset) > 0) : ($signed(s.offset) < 0));
    zero_reached  = s.motion.dir_pos ? ($signed(position_in) >= $signed(s.zero)) :
                                       ($signed(position_in) <= $signed(s.zero));
  end

  ////////////////////////////////////////////////////////////////////////////////

  always_comb begin
    next_s            = s;
    fin               = 1'b0;
    home_val          = position_in;
    next_s.rdata      = 32'h0;
    next_s.prev_lim_n = limit_neg_in;
    next_s.prev_lim_p = limit_pos_in;
    next_s.prev_idx   = index_in;
    next_s.prev_en    = enable_in;
    next_s.strap_taken = 1'b1;
    // Strap caught on the first clocked cycle after release
    if (!s.strap_taken) begin
      next_s.done = multiturn_in;
    end

    // Register writes
    if (wr_in) begin
      unique case (addr_in)
        shs_pkg::OFS_CTRL: begin
          next_s.method     = wdata_in[7:0];
          next_s.home_at_en = wdata_in[shs_pkg::CTRL_HAE_BIT];
          next_s.go_zero    = wdata_in[shs_pkg::CTRL_GOZ_BIT];
        end
        shs_pkg::OFS_OFFSET:  next_s.offset   = wdata_in;
        shs_pkg::OFS_MAXPATH: next_s.max_path = wdata_in;
        default: begin
          for (int i = 0; i < 3; i++) begin
            if (addr_in == shs_pkg::OFS_SPEED + 8'(4 * i)) begin
              next_s.speed[i] = wdata_in[15:0];
            end
            if (addr_in == shs_pkg::OFS_ACCEL + 8'(4 * i)) begin
              next_s.accel[i] = wdata_in[15:0];
            end
          end
        end
      endcase
    end

    // Register reads, data stands in the following cycle only
    if (rd_in) begin
      unique case (addr_in)
        shs_pkg::OFS_CTRL: next_s.rdata = {22'h0, s.go_zero, s.home_at_en, s.method};
        shs_pkg::OFS_STATUS: next_s.rdata = {21'h0, s.state, 2'h0, s.err_code,
                                             2'h0, s.err, s.done};
        shs_pkg::OFS_OFFSET:  next_s.rdata = s.offset;
        shs_pkg::OFS_MAXPATH: next_s.rdata = s.max_path;
        shs_pkg::OFS_HOME:    next_s.rdata = s.home;
        shs_pkg::OFS_ZERO:    next_s.rdata = s.zero;
        default: begin
          for (int i = 0; i < 3; i++) begin
            if (addr_in == shs_pkg::OFS_SPEED + 8'(4 * i)) begin
              next_s.rdata = {16'h0, s.speed[i]};
            end
            if (addr_in == shs_pkg::OFS_ACCEL + 8'(4 * i)) begin
              next_s.rdata = {16'h0, s.accel[i]};
            end
          end
        end
      endcase
    end

    start_req = (wr_in && addr_in == shs_pkg::OFS_CTRL && wdata_in[shs_pkg::CTRL_START_BIT]) ||
                (s.home_at_en && enable_in && !s.prev_en);

    unique case (s.state)
      shs_pkg::ST_IDLE: begin
      end
      shs_pkg::ST_SEARCH: begin
        if (kind_idx && idx_rise) begin
          fin = 1'b1;
        end else if ((kind_lim || kind_lim_idx) && lim_rise) begin
          next_s.state = shs_pkg::ST_CRAWL;
          next_s.rev   = 1'b1;
        end else if ((kind_lim || kind_lim_idx) && trav_abs > s.max_path) begin
          next_s.state    = shs_pkg::ST_IDLE;
          next_s.err      = 1'b1;
          next_s.err_code = shs_pkg::ERR_PATH;
          next_s.done     = 1'b0;
        end else if (kind_stop || kind_stop_idx) begin
          // Counter restarts whenever motion frees up again
          next_s.timer = blocked_in ? s.timer + 28'h1 : 28'h0;
          if (blocked_in && s.timer == STOP_LAST) begin
            if (kind_stop) begin
              fin = 1'b1;
            end else begin
              next_s.state = shs_pkg::ST_SEEK_INDEX;
              next_s.rev   = 1'b1;
            end
          end
        end
      end
      shs_pkg::ST_CRAWL: begin
        if (lim_fall) begin
          if (kind_lim) begin
            fin = 1'b1;
          end else begin
            next_s.state = shs_pkg::ST_SEEK_INDEX;
          end
        end
      end
      shs_pkg::ST_SEEK_INDEX: begin
        if (idx_rise) begin
          fin = 1'b1;
        end
      end
      shs_pkg::ST_GO_ZERO: begin
        if (zero_reached) begin
          next_s.state = shs_pkg::ST_IDLE;
          next_s.done  = 1'b1;
        end
      end
    endcase

    if (fin) begin
      next_s.home = home_val;
      next_s.zero = home_val + s.offset;
      if (!s.go_zero) begin
        next_s.state = shs_pkg::ST_IDLE;
        next_s.done  = 1'b1;
      end else if (beyond) begin
        next_s.state    = shs_pkg::ST_IDLE;
        next_s.err      = 1'b1;
        next_s.err_code = shs_pkg::ERR_BEYOND;
        next_s.done     = 1'b0;
      end else begin
        next_s.state = shs_pkg::ST_GO_ZERO;
        next_s.rev   = s.dir ^ ($signed(s.offset) > 0);
      end
    end

    // A new start overrides any run in progress
    if (start_req) begin
      next_s.done      = 1'b0;
      next_s.err       = 1'b0;
      next_s.err_code  = shs_pkg::ERR_NONE;
      next_s.start_pos = position_in;
      next_s.timer     = 28'h0;
      next_s.rev       = 1'b0;
      next_s.dir       = (next_s.method == shs_pkg::M_LIM_POS_IDX) ||
                         (next_s.method == shs_pkg::M_LIM_POS) ||
                         (next_s.method == shs_pkg::M_IDX_POS) ||
                         (next_s.method == shs_pkg::M_STOP_POS_IDX) ||
                         (next_s.method == shs_pkg::M_STOP_POS);
      unique case (next_s.method)
        shs_pkg::M_NONE: begin
          next_s.state = shs_pkg::ST_IDLE;
          next_s.home  = position_in;
          next_s.zero  = position_in + next_s.offset;
          next_s.done  = !next_s.go_zero;
          if (next_s.go_zero) begin
            next_s.state = shs_pkg::ST_GO_ZERO;
            // Search direction is negative here, so rev alone points toward zero
            next_s.rev   = $signed(next_s.offset) > 0;
          end
        end
        shs_pkg::M_LIM_NEG_IDX, shs_pkg::M_LIM_POS_IDX, shs_pkg::M_LIM_NEG,
        shs_pkg::M_LIM_POS, shs_pkg::M_IDX_NEG, shs_pkg::M_IDX_POS,
        shs_pkg::M_STOP_NEG_IDX, shs_pkg::M_STOP_POS_IDX, shs_pkg::M_STOP_NEG,
        shs_pkg::M_STOP_POS: begin
          next_s.state = shs_pkg::ST_SEARCH;
        end
        default: begin
          next_s.state    = shs_pkg::ST_IDLE;
          next_s.err      = 1'b1;
          next_s.err_code = shs_pkg::ERR_METHOD;
        end
      endcase
    end

    // Motion command per phase
    next_s.motion.active  = next_s.state != shs_pkg::ST_IDLE;
    next_s.motion.dir_pos = next_s.dir ^ next_s.rev;
    unique case (next_s.state)
      shs_pkg::ST_SEARCH: begin
        next_s.motion.speed = next_s.speed[shs_pkg::PH_SEARCH];
        next_s.motion.accel = next_s.accel[shs_pkg::PH_SEARCH];
      end
      shs_pkg::ST_CRAWL, shs_pkg::ST_SEEK_INDEX: begin
        next_s.motion.speed = next_s.speed[shs_pkg::PH_CRAWL];
        next_s.motion.accel = next_s.accel[shs_pkg::PH_CRAWL];
      end
      shs_pkg::ST_GO_ZERO: begin
        next_s.motion.speed = next_s.speed[shs_pkg::PH_RUN];
        next_s.motion.accel = next_s.accel[shs_pkg::PH_RUN];
      end
      shs_pkg::ST_IDLE: begin
        next_s.motion.speed = 16'h0;
        next_s.motion.accel = 16'h0;
      end
    endcase

    // Outputs only meaningful in positioning mode
    next_s.do_target = pos_mode_in && target_reached_in;
    next_s.do_remain = pos_mode_in && remaining_in;
    next_s.do_home   = pos_mode_in && next_s.done;
  end

  ////////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      s          <= '0;
      s.state    <= shs_pkg::ST_IDLE;
      s.method   <= shs_pkg::RST_METHOD;
      s.max_path <= shs_pkg::RST_MAXPATH;
      s.speed    <= shs_pkg::RST_SPEED;
      s.accel    <= shs_pkg::RST_ACCEL;
    end else begin
      s <= next_s;
    end
  end

  assign rdata_out     = s.rdata;
  assign motion_out    = s.motion;
  assign home_done_out = s.do_home;
  assign error_out     = s.err;
  assign target_out    = s.do_target;
  assign remain_out    = s.do_remain;
  assign zero_pos_out  = s.zero;

  ////////////////////////////////////////////////////////////////////////////////

  sequence seq_crawl_fall;
    s.state == shs_pkg::ST_CRAWL && kind_lim && lim_fall && !start_req;
  endsequence

  property p_strap;
    @(posedge clock_in) disable iff (reset_in)
      $rose(s.strap_taken) |-> s.done == $past(multiturn_in);
  endproperty
  a_strap: assert property (p_strap) else $error("home valid not from strap");

  property p_start_clears;
    @(posedge clock_in) disable iff (reset_in)
      (start_req && next_s.method != shs_pkg::M_NONE) |=> !s.done &&
        (s.err_code == shs_pkg::ERR_NONE || s.err_code == shs_pkg::ERR_METHOD);
  endproperty
  a_start_clears: assert property (p_start_clears) else $error("start kept done");

  property p_enable_start;
    @(posedge clock_in) disable iff (reset_in)
      (s.home_at_en && enable_in && !s.prev_en && !wr_in) |=> (s.motion.active || s.done || s.err);
  endproperty
  a_enable_start: assert property (p_enable_start) else $error("no run on enable");

  property p_none;
    @(posedge clock_in) disable iff (reset_in)
      (start_req && next_s.method == shs_pkg::M_NONE && !next_s.go_zero)
        |=> s.done && !s.motion.active && s.home == $past(position_in);
  endproperty
  a_none: assert property (p_none) else $error("no-move homing wrong");

  property p_search_speed;
    @(posedge clock_in) disable iff (reset_in)
      s.state == shs_pkg::ST_SEARCH |-> s.motion.speed == s.speed[shs_pkg::PH_SEARCH] &&
                                        s.motion.dir_pos == s.dir;
  endproperty
  a_search_speed: assert property (p_search_speed) else $error("search profile wrong");

  property p_crawl_speed;
    @(posedge clock_in) disable iff (reset_in)
      (s.state == shs_pkg::ST_CRAWL || s.state == shs_pkg::ST_SEEK_INDEX)
        |-> s.motion.speed == s.speed[shs_pkg::PH_CRAWL] && s.motion.dir_pos != s.dir;
  endproperty
  a_crawl_speed: assert property (p_crawl_speed) else $error("crawl profile wrong");

  property p_stop_time;
    @(posedge clock_in) disable iff (reset_in)
      (s.state == shs_pkg::ST_SEARCH && (kind_stop || kind_stop_idx) && !start_req &&
       next_s.state != shs_pkg::ST_SEARCH) |-> blocked_in && s.timer == STOP_LAST;
  endproperty
  a_stop_time: assert property (p_stop_time) else $error("stop taken too early");

  property p_path;
    @(posedge clock_in) disable iff (reset_in)
      (s.state == shs_pkg::ST_SEARCH && kind_lim && !lim_rise && trav_abs > s.max_path &&
       !start_req) |=> s.err && s.err_code == shs_pkg::ERR_PATH && !s.done;
  endproperty
  a_path: assert property (p_path) else $error("search path not checked");

  property p_beyond;
    @(posedge clock_in) disable iff (reset_in)
      (fin && s.go_zero && beyond && !start_req) |=> s.err && s.err_code == shs_pkg::ERR_BEYOND;
  endproperty
  a_beyond: assert property (p_beyond) else $error("zero beyond not flagged");

  property p_lim_fall_zero;
    @(posedge clock_in) disable iff (reset_in)
      seq_crawl_fall |=> s.home == $past(position_in) &&
                         s.zero == $past(position_in) + s.offset;
  endproperty
  a_lim_fall_zero: assert property (p_lim_fall_zero) else $error("switch edge not home");

  property p_home_out;
    @(posedge clock_in) disable iff (reset_in)
      ##1 home_done_out == ($past(pos_mode_in) && s.done);
  endproperty
  a_home_out: assert property (p_home_out) else $error("homed output wrong");

endmodule : shs_homing_sequencer

// ---- include/shs_pkg.sv ----
// Constants, codes and carrier types for the servo homing sequencer
package shs_pkg;

  localparam int          CLOCK_HZ       = 200_000_000;
  localparam int          STOP_TIME_MS   = 1000;
  localparam int          STOP_CYCLES    = (CLOCK_HZ / 1000) * STOP_TIME_MS;

  // Register byte offsets
  localparam logic [7:0]  OFS_CTRL       = 8'h00;
  localparam logic [7:0]  OFS_STATUS     = 8'h04;
  localparam logic [7:0]  OFS_OFFSET     = 8'h08;
  localparam logic [7:0]  OFS_MAXPATH    = 8'h0c;
  localparam logic [7:0]  OFS_SPEED      = 8'h10;
  localparam logic [7:0]  OFS_ACCEL      = 8'h1c;
  localparam logic [7:0]  OFS_HOME       = 8'h28;
  localparam logic [7:0]  OFS_ZERO       = 8'h2c;

  // Field positions
  localparam int          CTRL_HAE_BIT   = 8;
  localparam int          CTRL_GOZ_BIT   = 9;
  localparam int          CTRL_START_BIT = 16;

  // Method codes, two's complement bytes
  localparam logic [7:0]  M_LIM_NEG_IDX  = 8'h01;
  localparam logic [7:0]  M_LIM_POS_IDX  = 8'h02;
  localparam logic [7:0]  M_LIM_NEG      = 8'h11;
  localparam logic [7:0]  M_LIM_POS      = 8'h12;
  localparam logic [7:0]  M_IDX_NEG      = 8'h21;
  localparam logic [7:0]  M_IDX_POS      = 8'h22;
  localparam logic [7:0]  M_NONE         = 8'h23;
  localparam logic [7:0]  M_STOP_NEG_IDX = 8'hff;
  localparam logic [7:0]  M_STOP_POS_IDX = 8'hfe;
  localparam logic [7:0]  M_STOP_NEG     = 8'hef;
  localparam logic [7:0]  M_STOP_POS     = 8'hee;

  localparam logic [1:0]  ERR_NONE       = 2'h0;
  localparam logic [1:0]  ERR_PATH       = 2'h1;
  localparam logic [1:0]  ERR_BEYOND     = 2'h2;
  localparam logic [1:0]  ERR_METHOD     = 2'h3;

  // Phase indices into speed and accel tables
  localparam int          PH_SEARCH      = 0;
  localparam int          PH_CRAWL       = 1;
  localparam int          PH_RUN         = 2;

  // Reset values
  localparam logic [7:0]  RST_METHOD     = M_LIM_NEG;
  localparam logic [31:0] RST_MAXPATH    = 32'h0001_0000;
  localparam logic [47:0] RST_SPEED      = 48'h03e8_0019_0064;
  localparam logic [47:0] RST_ACCEL      = 48'h2710_00fa_03e8;

  typedef enum logic [2:0] {
    ST_IDLE, ST_SEARCH, ST_CRAWL, ST_SEEK_INDEX, ST_GO_ZERO
  } shs_state_t;

  typedef struct packed {
    logic        active;
    logic        dir_pos;
    logic [15:0] speed;
    logic [15:0] accel;
  } shs_motion_t;

  typedef struct packed {
    shs_state_t       state;
    logic [7:0]       method;
    logic             home_at_en;
    logic             go_zero;
    logic [31:0]      offset;
    logic [31:0]      max_path;
    logic [2:0][15:0] speed;
    logic [2:0][15:0] accel;
    logic             done;
    logic             err;
    logic [1:0]       err_code;
    logic             dir;
    logic             rev;
    logic [31:0]      start_pos;
    logic [31:0]      home;
    logic [31:0]      zero;
    logic [27:0]      timer;
    logic             prev_lim_n;
    logic             prev_lim_p;
    logic             prev_idx;
    logic             prev_en;
    logic             strap_taken;
    logic [31:0]      rdata;
    logic             do_target;
    logic             do_remain;
    logic             do_home;
    shs_motion_t      motion;
  } shs_regs_t;

endpackage : shs_pkg

// ---- testbench/shs_axis_model.sv ----
// Behavioural motor axis with limit switches, hard stops and encoder index
`timescale 1ns/10ps
module shs_axis_model #(
  parameter int LIMIT = 100,
  parameter int STOP  = 200
) (
  input  wire logic                 clock_in,
  input  wire logic                 load_in,
  input  wire logic [31:0]          load_pos_in,
  input  wire shs_pkg::shs_motion_t motion_in,
  output logic [31:0]               position_out,
  output logic                      limit_neg_out,
  output logic                      limit_pos_out,
  output logic                      index_out,
  output logic                      blocked_out
);
  logic signed [31:0] pos;
  logic               push_neg;
  logic               push_pos;
  assign push_neg = motion_in.active && !motion_in.dir_pos && pos <= -STOP;
  assign push_pos = motion_in.active && motion_in.dir_pos && pos >= STOP;
  // One count per cycle; speed only stretches time, so it is not modelled
  always_ff @(posedge clock_in) begin
    if (load_in) begin
      pos <= load_pos_in;
    end else if (motion_in.active && !push_neg && !push_pos) begin
      pos <= motion_in.dir_pos ? pos + 1 : pos - 1;
    end
  end
  assign position_out  = pos;
  assign limit_neg_out = pos <= -LIMIT;
  assign limit_pos_out = pos >= LIMIT;
  assign index_out     = pos[5:0] == 6'h00;
  assign blocked_out   = push_neg || push_pos;
endmodule : shs_axis_model

// ---- testbench/testbench.sv ----
// Self-checking bench: register port tasks and homing scenarios
`timescale 1ns/10ps
module testbench;
  localparam int STOP = 20;
  logic                 clock, reset, wr, rd, en, mt, pm, tr, rm, load;
  logic [7:0]           addr;
  logic [31:0]          wdata, rdata, pos, zpos, st, v, z, sp_p, sp_n;
  logic                 ln, lp, idx, blk, hd, eo, to, ro;
  shs_pkg::shs_motion_t mo;
  int                   errors, n_compared, brun, bmax;
  logic signed [31:0]   homes [11] = '{-99, 99, -64, 64, 0, 64, -192, 192, -200, 200, 10};
  logic [7:0]           codes [11] = '{8'h11, 8'h12, 8'h01, 8'h02, 8'h21, 8'h22, 8'hff,
                                       8'hfe, 8'hef, 8'hee, 8'h23};
  shs_homing_sequencer #(.STOP_CYCLES(STOP)) i_shs_homing_sequencer (
    .clock_in(clock), .reset_in(reset), .addr_in(addr), .wdata_in(wdata), .wr_in(wr),
    .rd_in(rd), .rdata_out(rdata), .position_in(pos), .limit_neg_in(ln), .limit_pos_in(lp),
    .index_in(idx), .blocked_in(blk), .enable_in(en), .multiturn_in(mt), .pos_mode_in(pm),
    .target_reached_in(tr), .remaining_in(rm), .motion_out(mo), .home_done_out(hd),
    .error_out(eo), .target_out(to), .remain_out(ro), .zero_pos_out(zpos));
  shs_axis_model i_shs_axis_model (.clock_in(clock), .load_in(load),
    .load_pos_in(32'h0000_000a), .motion_in(mo), .position_out(pos), .limit_neg_out(ln),
    .limit_pos_out(lp), .index_out(idx), .blocked_out(blk));
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // Last speed and accel seen per direction, longest blocked stretch
  always @(posedge clock) begin
    if (mo.active && mo.dir_pos) sp_p <= {mo.speed, mo.accel};
    if (mo.active && !mo.dir_pos) sp_n <= {mo.speed, mo.accel};
    brun <= blk ? brun + 1 : 0;
    if (blk && brun + 1 > bmax) bmax <= brun + 1;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Index and switch edges may land up to two counts either side
  task automatic near(input logic [31:0] seen, input logic [31:0] exp);
    chk({31'h0, (seen - exp + 32'h2) <= 32'h4}, 32'h1);
  endtask : near
  task automatic wrt(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask : wrt
  task automatic rdr(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    @(posedge clock);
    d = rdata;
  endtask : rdr
  task automatic go(input logic [7:0] m, input logic [31:0] x);
    @(posedge clock);
    load <= 1'b1;
    @(posedge clock);
    load <= 1'b0;
    wrt(shs_pkg::OFS_CTRL, x | 32'h0001_0000 | {24'h0, m});
  endtask : go
  task automatic wdone();
    int n;
    n = 0;
    st = 32'h0;
    while (st[1:0] === 2'b00 && n < 2000) begin
      rdr(shs_pkg::OFS_STATUS, st);
      n++;
    end
  endtask : wdone
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    errors++;
    finish_test();
  end
  initial begin
    {reset, load, wr, rd, en, mt, pm, tr, rm} = 9'h180;
    addr = 8'h00;
    wdata = 32'h0;
    {errors, n_compared, brun, bmax} = '0;
    {sp_p, sp_n} = '0;
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    load <= 1'b0;
    repeat (2) @(posedge clock);
    rdr(shs_pkg::OFS_STATUS, v);
    chk(v, 32'h0);
    rdr(shs_pkg::OFS_CTRL, v);
    chk(v, 32'h11);
    rdr(shs_pkg::OFS_SPEED, v);
    chk(v, 32'h64);
    rdr(8'h30, v);
    chk(v, 32'h0);
    tr <= 1'b1;
    pm <= 1'b1;
    repeat (3) @(posedge clock);
    chk({30'h0, to, ro}, 32'h2);
    pm <= 1'b0;
    repeat (3) @(posedge clock);
    chk({30'h0, to, ro}, 32'h0);
    pm <= 1'b1;
    tr <= 1'b0;
    rm <= 1'b1;
    repeat (3) @(posedge clock);
    chk({30'h0, to, ro}, 32'h1);
    $display("test reset and outputs done");
    for (int i = 0; i < 3; i++) begin
      wrt(shs_pkg::OFS_SPEED + 8'(4 * i), 32'(8'h11 * (i + 1)));
      wrt(shs_pkg::OFS_ACCEL + 8'(4 * i), 32'(8'h44 + 8'h11 * i));
    end
    wrt(shs_pkg::OFS_OFFSET, 32'h5);
    for (int i = 0; i < 11; i++) begin
      go(codes[i], 32'h0);
      wdone();
      chk({30'h0, st[1:0]}, 32'h1);
      rdr(shs_pkg::OFS_HOME, v);
      near(v, homes[i]);
      rdr(shs_pkg::OFS_ZERO, z);
      chk(z, v + 32'h5);
      chk(zpos, z);
      chk({31'h0, hd}, 32'h1);
      if (i == 0) begin
        chk(sp_n, 32'h0011_0044);
        chk(sp_p, 32'h0022_0055);
      end
    end
    chk(pos, 32'h0000_000a);
    chk({31'h0, bmax >= STOP}, 32'h1);
    $display("test methods done");
    go(8'h11, 32'h0);
    rdr(shs_pkg::OFS_STATUS, v);
    chk({31'h0, v[0]}, 32'h0);
    wdone();
    wrt(shs_pkg::OFS_OFFSET, 32'hffff_ffec);
    go(8'h12, 32'h200);
    wdone();
    chk({30'h0, st[1:0]}, 32'h1);
    near(pos, 32'h0000_004f);
    chk(sp_n, 32'h0033_0066);
    $display("test go to zero done");
    wrt(shs_pkg::OFS_OFFSET, 32'h14);
    go(8'h12, 32'h200);
    wdone();
    chk({26'h0, st[5:4], 2'h0, st[1:0]}, 32'h22);
    chk({31'h0, eo}, 32'h1);
    wrt(shs_pkg::OFS_MAXPATH, 32'h32);
    go(8'h11, 32'h0);
    wdone();
    chk({26'h0, st[5:4], 2'h0, st[1:0]}, 32'h12);
    go(8'h05, 32'h0);
    wdone();
    chk({26'h0, st[5:4], 2'h0, st[1:0]}, 32'h32);
    $display("test errors done");
    wrt(shs_pkg::OFS_CTRL, 32'h323);
    @(posedge clock);
    en <= 1'b1;
    wdone();
    chk({30'h0, st[1:0]}, 32'h1);
    rdr(shs_pkg::OFS_HOME, v);
    chk(v, 32'h0000_000a);
    near(pos, 32'h0000_001e);
    chk(sp_p, 32'h0033_0066);
    mt <= 1'b1;
    reset <= 1'b1;
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    repeat (2) @(posedge clock);
    rdr(shs_pkg::OFS_STATUS, v);
    chk({31'h0, v[0]}, 32'h1);
    $display("test enable and multiturn done");
    finish_test();
  end
endmodule : testbench
